/* File: dv/mtf_client_model.sv */
// remote modbus tcp client: sends request frames and collects replies
`timescale 1ns/1ps
module mtf_client_model (
  input  wire logic             clk_sys,
  output logic                  rxValid,
  output logic [7:0]            rxData,
  output logic                  rxLast,
  output mtf_pkg::mtf_rx_meta_t rxMeta,
  input  wire logic             rxReady,
  input  wire logic             txValid,
  input  wire logic [7:0]       txData,
  input  wire logic             txLast,
  output logic                  txReady
);
  logic [7:0] got[$];
  logic       gotLast = 1'b0;
  logic       slow    = 1'b0;
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    rxLast  = 1'b0;
    rxMeta  = '0;
    txReady = 1'b1;
  end
  // one frame in wire order, each byte held until taken
  task automatic send(input logic [7:0] q[$], input mtf_pkg::mtf_rx_meta_t m);
    for (int i = 0; i < q.size(); i++) begin
      @(negedge clk_sys);
      rxValid = 1'b1;
      rxData  = q[i];
      rxLast  = (i == q.size() - 1);
      rxMeta  = m;
      @(posedge clk_sys);
      while (!rxReady) @(posedge clk_sys);
    end
    @(negedge clk_sys);
    rxValid = 1'b0;
    rxLast  = 1'b0;
    rxData  = ~rxData;
    rxMeta  = ~rxMeta;
  endtask
  // reply bytes are kept on each handshake edge
  always @(posedge clk_sys) begin
    if (txValid && txReady) begin
      got.push_back(txData);
      if (txLast) gotLast <= 1'b1;
    end
  end
  // ready every cycle, or every other cycle when slow
  always @(negedge clk_sys) txReady <= slow ? ~txReady : 1'b1;
endmodule

/* File: dv/mtf_server_framing_sva.sv */
// port assertions for the modbus tcp server framing block
`timescale 1ns/1ps
`include "mtf_regs.svh"
module mtf_server_framing_sva #(
  parameter logic [23:0] MAKER_ID  = 24'h5a5a5a, // arbitrary value
  parameter logic [23:0] SERIAL_NO = 24'h000001  // arbitrary value
) (
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire logic [31:0]           ipAddress,
  input wire logic [47:0]           stationHwAddress,
  input wire logic                  rxValid,
  input wire logic [7:0]            rxData,
  input wire logic                  rxLast,
  input wire mtf_pkg::mtf_rx_meta_t rxMeta,
  input wire logic                  rxReady,
  input wire logic                  txValid,
  input wire logic [7:0]            txData,
  input wire logic                  txLast,
  input wire logic                  txReady,
  input wire logic                  reqStrobe,
  input wire mtf_pkg::mtf_req_t     reqInfo
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // receive-side mirror of the frame checks, from the ports alone
  logic [3:0] seenIdx_r;
  logic       seenBad_r;
  wire        rxTake  = rxValid && rxReady;
  wire        pidByte = (seenIdx_r == `MTF_IDX_PID_HI) ||
                        (seenIdx_r == `MTF_IDX_PID_LO);
  wire        byteOk  = rxMeta.isTcp &&
                        (rxMeta.dstPort == `MTF_TCP_PORT) &&
                        (rxMeta.dstIp == ipAddress) &&
                        !(pidByte && (rxData != `MTF_PROTO_ID));
  wire        frameOk = !seenBad_r && byteOk &&
                        (seenIdx_r >= `MTF_IDX_FUNC);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seenIdx_r <= 4'h0;
      seenBad_r <= 1'b0;
    end else if (rxTake && rxLast) begin
      seenIdx_r <= 4'h0;
      seenBad_r <= 1'b0;
    end else if (rxTake) begin
      seenIdx_r <= (seenIdx_r == `MTF_IDX_FULL) ? seenIdx_r :
                                                  seenIdx_r + 4'h1;
      seenBad_r <= seenBad_r || !byteOk;
    end
  end
  // station address is fixed maker id then serial number
  hw_addr_a: assert property (stationHwAddress == {MAKER_ID, SERIAL_NO})
    else $error("station address wrong");
  // a reply byte waits unchanged until the client takes it
  reply_hold_a: assert property (txValid && !txReady |=>
    txValid && $stable(txData) && $stable(txLast))
    else $error("reply byte changed before taken");
  // the reply ends on the byte marked last
  reply_end_a: assert property (txValid && txReady && txLast |=> !txValid)
    else $error("reply continued after last byte");
  last_flag_a: assert property (txLast |-> txValid)
    else $error("last flag without valid");
  // no new request while a reply is pending
  rx_closed_a: assert property (txValid |-> !rxReady)
    else $error("request taken during reply");
  frame_close_a: assert property (rxTake && rxLast && frameOk |=> !rxReady)
    else $error("receive stayed open after last byte");
  // a refused frame leaves receive open and starts no reply
  frame_drop_a: assert property (rxTake && rxLast && !frameOk |=>
    rxReady && !txValid)
    else $error("refused frame was not dropped");
  // frames outside tcp port 502 never reach the application
  port_drop_a: assert property (rxValid && rxReady && rxLast &&
    (!rxMeta.isTcp || rxMeta.dstPort != `MTF_TCP_PORT) |=> !reqStrobe [*3])
    else $error("foreign frame raised a request");
  strobe_pulse_a: assert property (reqStrobe |=> !reqStrobe)
    else $error("request strobe longer than one cycle");
  strobe_func_a: assert property (reqStrobe |->
    reqInfo.func inside {`MTF_FC_READ_HOLD, `MTF_FC_READ_IN,
                         `MTF_FC_WRITE_ONE, `MTF_FC_WRITE_MANY,
                         `MTF_FC_READ_WRITE})
    else $error("request strobe for unserved function");
endmodule
bind mtf_server_framing mtf_server_framing_sva #(
  .MAKER_ID(MAKER_ID), .SERIAL_NO(SERIAL_NO)) i_mtf_server_framing_sva (
  .clk_sys(clk_sys), .arst_n(arst_n), .stationHwAddress(stationHwAddress),
  .ipAddress(ipAddress), .rxData(rxData),
  .rxValid(rxValid), .rxLast(rxLast), .rxMeta(rxMeta), .rxReady(rxReady),
  .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
  .reqStrobe(reqStrobe), .reqInfo(reqInfo));

/* File: dv/tb_top.sv */
// self-checking testbench for the modbus tcp server framing block
`timescale 1ns/1ps
`include "mtf_regs.svh"
module tb_top;
  localparam logic [31:0] DEV_IP = 32'hc0a80a14;
  localparam logic [23:0] MK     = 24'h3c3c3c; // arbitrary value
  localparam logic [23:0] SN     = 24'h00a001; // arbitrary value
  localparam mtf_pkg::mtf_rx_meta_t GOOD = '{1'b1, `MTF_TCP_PORT, DEV_IP};
  logic                  clk_sys = 1'b0;
  logic                  arst_n  = 1'b0;
  logic [2:0]            lv      = 3'h0;
  logic                  appValid = 1'b0;
  logic [7:0]            appData  = 8'h00;
  logic                  appLast  = 1'b0;
  logic [7:0]            appLen   = 8'h00;
  logic                  rxValid, rxLast, rxReady, txValid, txLast, txReady;
  logic [7:0]            rxData, txData;
  logic [47:0]           stationHwAddress;
  logic                  reqStrobe, appReady;
  mtf_pkg::mtf_rx_meta_t rxMeta;
  mtf_pkg::mtf_req_t     reqInfo, lastReq;
  logic [7:0]            req[$];
  logic [7:0]            expq[$];
  int                    error_cnt = 0;
  int                    tests_run = 0;
  int                    strobeCnt = 0;
  always #50 clk_sys = ~clk_sys;
  mtf_server_framing #(.MAKER_ID(MK), .SERIAL_NO(SN)) i_mtf_server_framing (
    .clk_sys(clk_sys), .arst_n(arst_n), .ipAddress(DEV_IP),
    .stationHwAddress(stationHwAddress), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast), .rxMeta(rxMeta), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txReady(txReady),
    .watchdogExpired(lv[2]), .termBusFault(lv[1]),
    .outputsOwnedElsewhere(lv[0]), .reqStrobe(reqStrobe), .reqInfo(reqInfo),
    .appValid(appValid), .appData(appData), .appLast(appLast),
    .appLen(appLen), .appReady(appReady));
  mtf_client_model i_mtf_client_model (
    .clk_sys(clk_sys), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
    .rxMeta(rxMeta), .rxReady(rxReady), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txReady(txReady));
  // counts application requests and keeps the latest one
  always @(posedge clk_sys) begin
    if (reqStrobe === 1'b1) begin
      strobeCnt <= strobeCnt + 1;
      lastReq   <= reqInfo;
    end
  end
  task automatic cmp(input string what, input logic [47:0] e, a);
    tests_run++;
    if (e !== a) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, e, a);
    end
  endtask
  // twelve byte request: header, function, address, count or value
  task automatic build(input logic [15:0] t, input logic [7:0] u, f,
                       input logic [15:0] a, n);
    req = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'h06, u, f,
           a[15:8], a[7:0], n[15:8], n[7:0]};
  endtask
  // send the request and wait a bounded time for the whole reply
  task automatic xfer(input mtf_pkg::mtf_rx_meta_t m);
    i_mtf_client_model.got.delete();
    i_mtf_client_model.gotLast = 1'b0;
    i_mtf_client_model.send(req, m);
    repeat (80) begin
      if (!i_mtf_client_model.gotLast) @(posedge clk_sys);
    end
    @(negedge clk_sys);
  endtask
  task automatic chkReply(input string what);
    cmp({what, " size"}, expq.size(), i_mtf_client_model.got.size());
    foreach (expq[i]) cmp(what, expq[i], i_mtf_client_model.got[i]);
  endtask
  task automatic excCase(input logic [7:0] f, input logic [15:0] a, n,
                         input logic [2:0] l, input logic [7:0] code);
    build({code, f}, ~f, f, a, n);
    @(negedge clk_sys);
    lv = l;
    xfer(GOOD);
    lv = 3'h0;
    expq = {req[0], req[1], 8'h00, 8'h00, 8'h00, 8'h03, req[6], f | 8'h80,
            code};
    chkReply("exception reply");
  endtask
  task automatic test_station;
    cmp("station address", {MK, SN}, stationHwAddress);
  endtask
  task automatic test_exc_codes;
    excCase(8'h2b, 16'h0800, 16'h0001, 3'h0, 8'h01);
    excCase(8'h41, 16'h0000, 16'h0001, 3'h4, 8'h01);
    excCase(8'h03, 16'h0100, 16'h0001, 3'h0, 8'h02);
    excCase(8'h04, 16'h0000, 16'h007e, 3'h0, 8'h02);
    excCase(8'h08, 16'h0001, 16'h0000, 3'h0, 8'h03);
    excCase(8'h03, 16'h0800, 16'h0002, 3'h4, 8'h04);
    excCase(8'h04, 16'h0000, 16'h0002, 3'h2, 8'h04);
    excCase(8'h06, 16'h0803, 16'h3fff, 3'h1, 8'h06);
    excCase(8'h10, 16'h0800, 16'h0001, 3'h1, 8'h06);
    excCase(8'h17, 16'h0100, 16'h0001, 3'h0, 8'h02);
  endtask
  task automatic test_echo;
    int k;
    k = strobeCnt;
    i_mtf_client_model.slow = 1'b1;
    build(16'h7e81, 8'h00, 8'h06, 16'h0803, 16'h3fff);
    xfer(GOOD);
    expq = req;
    chkReply("write echo");
    cmp("write address", 16'h0803, lastReq.addr);
    build(16'h0000, 8'hff, 8'h08, 16'h0000, 16'habcd);
    xfer(GOOD);
    i_mtf_client_model.slow = 1'b0;
    expq = req;
    chkReply("diag echo");
    cmp("strobes", k + 1, strobeCnt);
  endtask
  task automatic test_app;
    logic [7:0] pdu[$];
    pdu = {8'h04, 8'h02, 8'h00, 8'h38};
    build(16'hbeef, 8'hff, 8'h04, 16'h0000, `MTF_MAX_WORDS);
    fork
      xfer(GOOD);
      foreach (pdu[i]) begin
        @(negedge clk_sys);
        appValid = 1'b1;
        appData  = pdu[i];
        appLast  = (i == 3);
        appLen   = 8'h04;
        @(posedge clk_sys);
        while (!appReady) @(posedge clk_sys);
      end
    join
    appValid = 1'b0;
    appData  = ~appData;
    expq = {8'hbe, 8'hef, 8'h00, 8'h00, 8'h00, 8'h05, 8'hff, pdu};
    chkReply("app reply");
    cmp("request fields", {8'h04, 16'h0000, 16'h007d},
        {lastReq.func, lastReq.addr, lastReq.count});
    cmp("request ids", {16'hbeef, 8'hff},
        {lastReq.txnId, lastReq.unitId});
  endtask
  task automatic test_drops;
    mtf_pkg::mtf_rx_meta_t m;
    int k;
    k = strobeCnt;
    build(16'h0102, 8'h01, 8'h03, 16'h0800, 16'h0002);
    m = GOOD;
    m.dstPort = 16'h01f7;
    xfer(m);
    cmp("port 503 reply", 0, i_mtf_client_model.got.size());
    m = GOOD;
    m.isTcp = 1'b0;
    xfer(m);
    cmp("udp reply", 0, i_mtf_client_model.got.size());
    m = GOOD;
    m.dstIp = ~DEV_IP;
    xfer(m);
    cmp("foreign ip reply", 0, i_mtf_client_model.got.size());
    req[3] = 8'h01;
    xfer(GOOD);
    cmp("protocol id reply", 0, i_mtf_client_model.got.size());
    cmp("dropped strobes", k, strobeCnt);
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #2ms;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    test_exc_codes;
    test_station;
    test_echo;
    test_drops;
    test_app;
    report_and_stop;
  end
endmodule

/* File: hw/mtf_pkg.sv */
// types for the modbus tcp server framing block
package mtf_pkg;
  // transport facts that travel with each received byte
  typedef struct packed {
    logic        isTcp;
    logic [15:0] dstPort;
    logic [31:0] dstIp;
  } mtf_rx_meta_t;

  // request handed to the application logic
  typedef struct packed {
    logic [15:0] txnId;
    logic [7:0]  unitId;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] count;
  } mtf_req_t;

  typedef enum logic [2:0] {
    ST_RX   = 3'b000,
    ST_EVAL = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b011,
    ST_APP  = 3'b100
  } mtf_state_t;

  typedef enum logic [1:0] {
    K_EXC  = 2'b00,
    K_ECHO = 2'b01,
    K_APP  = 2'b10
  } mtf_kind_t;
endpackage

/* File: hw/mtf_regs.svh */
// constants for the modbus tcp server framing block
`ifndef MTF_REGS_SVH
`define MTF_REGS_SVH
`define MTF_TCP_PORT      16'h01f6
`define MTF_PROTO_ID      8'h00
`define MTF_EXC_FLAG      8'h80
`define MTF_EXC_LEN       16'h0003
`define MTF_ECHO_LEN      16'h0006
`define MTF_IDX_TXN_HI    4'h0
`define MTF_IDX_TXN_LO    4'h1
`define MTF_IDX_PID_HI    4'h2
`define MTF_IDX_PID_LO    4'h3
`define MTF_IDX_LEN_HI    4'h4
`define MTF_IDX_LEN_LO    4'h5
`define MTF_IDX_UNIT      4'h6
`define MTF_IDX_FUNC      4'h7
`define MTF_IDX_A_HI      4'h8
`define MTF_IDX_A_LO      4'h9
`define MTF_IDX_N_HI      4'ha
`define MTF_IDX_N_LO      4'hb
`define MTF_IDX_FULL      4'hc
`define MTF_IDX_EXC_LAST  4'h8
`define MTF_IDX_ECHO_LAST 4'hb
`define MTF_IDX_HDR_LAST  4'h6
`define MTF_FC_READ_HOLD  8'h03
`define MTF_FC_READ_IN    8'h04
`define MTF_FC_WRITE_ONE  8'h06
`define MTF_FC_DIAG       8'h08
`define MTF_FC_WRITE_MANY 8'h10
`define MTF_FC_READ_WRITE 8'h17
`define MTF_ERR_FUNC      8'h01
`define MTF_ERR_ADDR      8'h02
`define MTF_ERR_VALUE     8'h03
`define MTF_ERR_DEVICE    8'h04
`define MTF_ERR_BUSY      8'h06
`define MTF_IN_BASE       16'h0000
`define MTF_IN_TOP        16'h00ff
`define MTF_OUT_BASE      16'h0800
`define MTF_OUT_TOP       16'h08ff
`define MTF_MAX_WORDS     16'h007d
`define MTF_DIAG_ECHO     16'h0000
`endif

/* File: hw/mtf_server_framing.sv */
// modbus tcp server framing: header check, echo and exception replies
// How it works
// - only requests to tcp port 502 are taken as modbus frames
// - frames that did not arrive over tcp are ignored here
// - modbus framing runs from reset with no enable at all
// - header is seven bytes, function at byte 7, protocol id zero
// - transaction id bytes 0 and 1 copied unchanged into the reply
// - any unit id accepted and echoed in byte 6
// - byte 5 counts following bytes, byte 4 zero below 256
// - unserved requests get function field plus one error code byte
// - exception function field is request function plus 0x80
// - code 1 for unknown function, code 3 for bad values
// - code 2 when start address or word count is out of range
// - code 4 when watchdog expired or terminal bus faulted
// - code 6 for output writes while another station owns outputs
// - requests must target the user set four byte ip address
// - six byte station address: maker id then unit serial number
// - single register write answered with a copy of the request
`timescale 1ns/1ps
`include "mtf_regs.svh"
module mtf_server_framing #(
  parameter logic [23:0] MAKER_ID  = 24'h5a5a5a, // arbitrary value
  parameter logic [23:0] SERIAL_NO = 24'h000001  // arbitrary value
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic [31:0]           ipAddress,
  output logic [47:0]                stationHwAddress,
  input  wire logic                  rxValid,
  input  wire logic [7:0]            rxData,
  input  wire logic                  rxLast,
  input  wire mtf_pkg::mtf_rx_meta_t rxMeta,
  output logic                       rxReady,
  output logic                       txValid,
  output logic [7:0]                 txData,
  output logic                       txLast,
  input  wire logic                  txReady,
  input  wire logic                  watchdogExpired,
  input  wire logic                  termBusFault,
  input  wire logic                  outputsOwnedElsewhere,
  output logic                       reqStrobe,
  output mtf_pkg::mtf_req_t          reqInfo,
  input  wire logic                  appValid,
  input  wire logic [7:0]            appData,
  input  wire logic                  appLast,
  input  wire logic [7:0]            appLen,
  output logic                       appReady
);

  mtf_pkg::mtf_state_t state_r;
  mtf_pkg::mtf_kind_t  kind_r;
  logic [7:0]          hdr_r [0:11];
  logic [3:0]          rxIdx_r;
  logic                rxBad_r;
  logic [3:0]          txIdx_r;
  logic [7:0]          excCode_r;
  logic [15:0]         lenField_r;
  logic                txValid_r;
  logic [7:0]          txData_r;
  logic                txLast_r;
  logic                reqStrobe_r;
  mtf_pkg::mtf_req_t   reqInfo_r;

  // word range check shared by all address-bearing functions
  function automatic logic rangeOk(input logic [15:0] a,
                                   input logic [15:0] n,
                                   input logic [15:0] base,
                                   input logic [15:0] top);
    logic [16:0] lastWord;
    lastWord = {1'b0, a} + {1'b0, n} - 17'h00001;
    rangeOk  = (n != 16'h0000) && (n <= `MTF_MAX_WORDS) &&
               (a >= base) && (lastWord <= {1'b0, top});
  endfunction

  // station address and ip match
  assign stationHwAddress = {MAKER_ID, SERIAL_NO};
  wire metaOk = rxMeta.isTcp &&
                (rxMeta.dstPort == `MTF_TCP_PORT) &&
                (rxMeta.dstIp == ipAddress);

  // byte that would land in the protocol id slots must be zero
  wire pidSlot = (rxIdx_r == `MTF_IDX_PID_HI) ||
                 (rxIdx_r == `MTF_IDX_PID_LO);
  wire byteBad = !metaOk ||
                 (pidSlot && (rxData != `MTF_PROTO_ID));
  wire rxTake  = rxValid && rxReady;

  // request fields decoded from the captured header
  wire [7:0]  reqFunc  = hdr_r[`MTF_IDX_FUNC];
  wire [15:0] reqAddr  = {hdr_r[`MTF_IDX_A_HI], hdr_r[`MTF_IDX_A_LO]};
  wire [15:0] reqCount = {hdr_r[`MTF_IDX_N_HI], hdr_r[`MTF_IDX_N_LO]};
  wire [15:0] reqLen   = {hdr_r[`MTF_IDX_LEN_HI], hdr_r[`MTF_IDX_LEN_LO]};
  wire        fullBody = (rxIdx_r == `MTF_IDX_FULL);

  wire isRdHold = reqFunc == `MTF_FC_READ_HOLD;
  wire isRdIn   = reqFunc == `MTF_FC_READ_IN;
  wire isWrOne  = reqFunc == `MTF_FC_WRITE_ONE;
  wire isDiag   = reqFunc == `MTF_FC_DIAG;
  wire isWrMany = reqFunc == `MTF_FC_WRITE_MANY;
  wire isRdWr   = reqFunc == `MTF_FC_READ_WRITE;
  wire known    = isRdHold || isRdIn || isWrOne || isDiag ||
                  isWrMany || isRdWr;
  wire isWrite  = isWrOne || isWrMany || isRdWr;

  // address and count checks per function
  wire inOk    = rangeOk(reqAddr, reqCount, `MTF_IN_BASE, `MTF_IN_TOP);
  wire outOk   = rangeOk(reqAddr, reqCount, `MTF_OUT_BASE, `MTF_OUT_TOP);
  wire oneOk   = rangeOk(reqAddr, 16'h0001, `MTF_OUT_BASE, `MTF_OUT_TOP);
  wire addrOk  = isRdHold ? (inOk || outOk) :
                 isRdIn   ? inOk :
                 isWrOne  ? oneOk :
                 isWrMany ? outOk :
                 isRdWr   ? inOk : 1'b1;
  wire echoLen = reqLen == `MTF_ECHO_LEN;
  wire valueOk = fullBody &&
                 (!(isWrOne || isDiag) || echoLen) &&
                 (!isDiag || (reqAddr == `MTF_DIAG_ECHO));

  // exception code selection in priority order
  wire [7:0] errCode =
    !known                          ? `MTF_ERR_FUNC :
    (watchdogExpired||termBusFault) ? `MTF_ERR_DEVICE :
    (isWrite&&outputsOwnedElsewhere)? `MTF_ERR_BUSY :
    !addrOk                         ? `MTF_ERR_ADDR :
    !valueOk                        ? `MTF_ERR_VALUE :
                                      8'h00;
  wire needExc = errCode != 8'h00;
  wire [1:0] evalKindBits = needExc ? mtf_pkg::K_EXC :
                            (isWrOne || isDiag) ? mtf_pkg::K_ECHO :
                            mtf_pkg::K_APP;
  wire [3:0] lastIdx = (kind_r == mtf_pkg::K_EXC)  ? `MTF_IDX_EXC_LAST :
                       (kind_r == mtf_pkg::K_ECHO) ? `MTF_IDX_ECHO_LAST :
                                                     `MTF_IDX_HDR_LAST;

  // reply byte at a given index
  function automatic logic [7:0] frameByte(input logic [3:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx == `MTF_IDX_TXN_HI || idx == `MTF_IDX_TXN_LO ||
        idx == `MTF_IDX_UNIT) begin
      b = hdr_r[idx];
    end else if (idx == `MTF_IDX_PID_HI || idx == `MTF_IDX_PID_LO) begin
      b = `MTF_PROTO_ID;
    end else if (idx == `MTF_IDX_LEN_HI) begin
      b = lenField_r[15:8];
    end else if (idx == `MTF_IDX_LEN_LO) begin
      b = lenField_r[7:0];
    end else if (kind_r == mtf_pkg::K_EXC && idx == `MTF_IDX_FUNC) begin
      b = hdr_r[`MTF_IDX_FUNC] | `MTF_EXC_FLAG;
    end else if (kind_r == mtf_pkg::K_EXC) begin
      b = excCode_r;
    end else if (idx <= `MTF_IDX_ECHO_LAST) begin
      b = hdr_r[idx];
    end
    frameByte = b;
  endfunction

  // handshake decode
  wire       txFire   = txValid_r && txReady;
  wire       sendEnd  = (state_r == mtf_pkg::ST_SEND) && txFire &&
                        (txIdx_r == lastIdx);
  wire [3:0] txIdxInc = txIdx_r + 4'h1;
  logic [7:0] nextByte;
  // a process, so that header and kind read inside the function wake it
  always_comb begin
    nextByte = frameByte(txIdxInc);
  end
  wire       appSlot  = !txValid_r || txReady;
  assign rxReady  = state_r == mtf_pkg::ST_RX;
  assign appReady = (state_r == mtf_pkg::ST_APP) && appSlot &&
                    !(txValid_r && txLast_r);
  assign txValid   = txValid_r;
  assign txData    = txData_r;
  assign txLast    = txLast_r;
  assign reqStrobe = reqStrobe_r;
  assign reqInfo   = reqInfo_r;

  // header capture, first twelve bytes kept
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 12; i++) begin
        hdr_r[i] <= 8'h00;
      end
    end else if (rxTake && !rxIdx_r[3]) begin
      hdr_r[rxIdx_r] <= rxData;
    end else if (rxTake && rxIdx_r < `MTF_IDX_FULL) begin
      hdr_r[rxIdx_r] <= rxData;
    end
  end

  // saturating byte index; frame is good once every byte passed and
  // the function byte arrived
  wire [3:0] rxIdxNext = (rxIdx_r == `MTF_IDX_FULL) ? rxIdx_r :
                                                       rxIdx_r + 4'h1;
  wire       frameGood = !rxBad_r && !byteBad &&
                         (rxIdx_r >= `MTF_IDX_FUNC);

  // receive index and frame validity; a dropped frame restarts at byte 0
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxIdx_r <= 4'h0;
      rxBad_r <= 1'b0;
    end else if (rxTake && rxLast) begin
      rxIdx_r <= frameGood ? rxIdxNext : 4'h0;
      rxBad_r <= 1'b0;
    end else if (rxTake) begin
      rxIdx_r <= rxIdxNext;
      rxBad_r <= rxBad_r | byteBad;
    end else if (state_r == mtf_pkg::ST_RX) begin
      rxIdx_r <= rxIdx_r;
    end else if (sendEnd || state_r == mtf_pkg::ST_APP) begin
      rxIdx_r <= 4'h0;
    end
  end

  // main sequencer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= mtf_pkg::ST_RX;
    end else begin
      unique case (state_r)
        mtf_pkg::ST_RX: begin
          if (rxTake && rxLast) begin
            state_r <= frameGood ? mtf_pkg::ST_EVAL : mtf_pkg::ST_RX;
          end
        end
        mtf_pkg::ST_EVAL: begin
          state_r <= (evalKindBits == mtf_pkg::K_APP) ?
                     mtf_pkg::ST_WAIT : mtf_pkg::ST_SEND;
        end
        mtf_pkg::ST_WAIT: begin
          if (appValid) begin
            state_r <= mtf_pkg::ST_SEND;
          end
        end
        mtf_pkg::ST_SEND: begin
          if (sendEnd) begin
            state_r <= (kind_r == mtf_pkg::K_APP) ?
                       mtf_pkg::ST_APP : mtf_pkg::ST_RX;
          end
        end
        mtf_pkg::ST_APP: begin
          if (txValid_r && txLast_r && txReady) begin
            state_r <= mtf_pkg::ST_RX;
          end
        end
        default: state_r <= mtf_pkg::ST_RX;
      endcase
    end
  end

  // reply kind, code and length field
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      kind_r     <= mtf_pkg::K_EXC;
      excCode_r  <= 8'h00;
      lenField_r <= 16'h0000;
    end else if (state_r == mtf_pkg::ST_EVAL) begin
      kind_r     <= mtf_pkg::mtf_kind_t'(evalKindBits);
      excCode_r  <= errCode;
      lenField_r <= needExc ? `MTF_EXC_LEN : reqLen;
    end else if (state_r == mtf_pkg::ST_WAIT && appValid) begin
      lenField_r <= {8'h00, appLen} + 16'h0001;
    end
  end

  // request hand-off to the application for accepted requests other than diagnostics
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reqStrobe_r <= 1'b0;
      reqInfo_r   <= '0;
    end else begin
      reqStrobe_r <= (state_r == mtf_pkg::ST_EVAL) && !needExc && !isDiag;
      if (state_r == mtf_pkg::ST_EVAL) begin
        reqInfo_r <= '{txnId: {hdr_r[`MTF_IDX_TXN_HI],
                               hdr_r[`MTF_IDX_TXN_LO]},
                       unitId: hdr_r[`MTF_IDX_UNIT],
                       func: reqFunc, addr: reqAddr, count: reqCount};
      end
    end
  end

  // transmit byte register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txIdx_r   <= 4'h0;
      txValid_r <= 1'b0;
      txData_r  <= 8'h00;
      txLast_r  <= 1'b0;
    end else if ((state_r == mtf_pkg::ST_EVAL && needExc) ||
                 (state_r == mtf_pkg::ST_EVAL && (isWrOne || isDiag)) ||
                 (state_r == mtf_pkg::ST_WAIT && appValid)) begin
      txIdx_r   <= 4'h0;
      txValid_r <= 1'b1;
      txData_r  <= hdr_r[`MTF_IDX_TXN_HI]; // byte 0 stands with valid
      txLast_r  <= 1'b0;
    end else if (state_r == mtf_pkg::ST_SEND && txIdx_r == 4'h0 &&
                 !txFire) begin
      txData_r  <= hdr_r[`MTF_IDX_TXN_HI];
    end else if (sendEnd) begin
      txValid_r <= 1'b0;
      txLast_r  <= 1'b0;
    end else if (state_r == mtf_pkg::ST_SEND && txFire) begin
      txIdx_r   <= txIdxInc;
      txData_r  <= nextByte;
      txLast_r  <= (txIdxInc == lastIdx) && (kind_r != mtf_pkg::K_APP);
    end else if (state_r == mtf_pkg::ST_APP && appSlot) begin
      txValid_r <= appValid && appReady;
      txData_r  <= appValid ? appData : txData_r;
      txLast_r  <= appValid && appReady && appLast;
    end
  end

endmodule
